// *** verilog/ctp_pkg.sv ***
// constants and types for the cascaded 16-bit timer with pwm output
package ctp_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          PRE_W       = 11;
    // register byte offsets
    localparam logic [7:0]  OFS_LCTRL   = 8'h00;
    localparam logic [7:0]  OFS_UCTRL   = 8'h04;
    localparam logic [7:0]  OFS_CMP_LO  = 8'h08;
    localparam logic [7:0]  OFS_CMP_HI  = 8'h0c;
    localparam logic [7:0]  OFS_DUTY_LO = 8'h10;
    localparam logic [7:0]  OFS_DUTY_HI = 8'h14;
    localparam logic [7:0]  OFS_COUNT   = 8'h18;
    localparam logic [7:0]  OFS_STATUS  = 8'h1c;
    localparam logic [7:0]  OFS_CFG     = 8'h20;
    // field positions
    localparam int          UC_FF_BIT   = 7;
    localparam int          UC_RUN_BIT  = 3;
    localparam int          LC_SRC_LSB  = 4;
    localparam int          CFG_DV_BIT  = 0;
    localparam int          CFG_SLOW_BIT = 1;
    // reset values, counter top value and bus response codes
    localparam logic [7:0]  LCTRL_RST   = 8'h00;
    localparam logic [7:0]  CFG_RST     = 8'h00;
    localparam logic [15:0] CNT_TOP     = 16'hffff;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    // counting modes, in upper control bits 1:0
    typedef enum logic [1:0] {
        CTP_MODE_TIMER,
        CTP_MODE_EVENT,
        CTP_MODE_PWM,
        CTP_MODE_RSVD
    } ctp_mode_e;
    // source clock select, in lower control bits 6:4
    typedef enum logic [2:0] {
        CTP_SRC_DIV11,
        CTP_SRC_DIV7,
        CTP_SRC_DIV5,
        CTP_SRC_DIV3,
        CTP_SRC_LOW,
        CTP_SRC_DIV1,
        CTP_SRC_HIGH,
        CTP_SRC_EXT
    } ctp_src_e;
endpackage

// *** verilog/ctp_timer.sv ***
// cascaded 16-bit timer, event counter and pwm generator with axi4-lite registers
// Notes on behaviour
// R1: two 8-bit halves form one 16-bit up-counter; timer mode counts prescaled clock
// R2: timer mode: match with compare raises irq, clears counter, counting continues
// R3: run bit is bit 3 of upper control; 1 starts, 0 stops
// R4: software writes compare upper byte then lower byte in timer mode
// R5: software keeps flop init bit at 0 in timer and event modes
// R6: compare has no shadow, takes effect at once; keep it still while running
// R7: event mode counts falling edges of the event input
// R8: event mode: match raises irq and clears; counting resumes on next falling edge
// R9: event input holds each level at least two machine cycles
// R10: software writes compare lower byte then upper byte in event mode
// R11: pwm mode gives 16 bits, counting internal or external clock
// R12: pwm: counter equal to duty toggles the flop, counter keeps counting
// R13: pwm: overflow toggles flop again, clears counter, raises irq
// R14: flop initial value from bit 7 of upper control; reset clears it
// R15: pwm pin always drives inverse of the flop
// R16: duty double-buffered: running writes load at period end, stopped at once
// R17: duty reads return the active value until the period-end irq
// R18: software writes duty lower byte then upper byte, never one alone
// R19: software updates duty right after the period-end irq; t_pwm writes it mid-period, right after the duty match
// R20: stopping holds the pin; flop bit changes only in a later write
// R21: software stops the timer before entering stop power mode
// R22: sources: high/2^11 (low/2^3), /2^7, /2^5, /2^3; pwm adds low, high/2, high
// R23: pwm period is 65536 source cycles
`timescale 1ns/1ps
`default_nettype none
module ctp_timer (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic [ctp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [ctp_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      low_clock,
    input  wire logic                      event_input_pin,
    output logic                           pwm_output_pin,
    output logic                           upper_counter_irq
);
    typedef struct packed {
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       aw_got;
        logic                       w_got;
        logic [ctp_pkg::ADDR_W-1:0] waddr;
        logic [7:0]                 wbyte;
        logic                       wlane;
        logic                       arready;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [31:0]                rdata;
        logic [7:0]                 lctrl;
        logic [7:0]                 cfg;
        logic                       run;
        logic                       ff_init;
        ctp_pkg::ctp_mode_e         mode;
        logic [15:0]                cmp;
        logic [15:0]                duty_buf;
        logic [15:0]                duty_act;
        logic [15:0]                cnt;
        logic                       ff;
        logic                       pin;
        logic                       irq;
        logic [ctp_pkg::PRE_W-1:0]  pre;
        logic [2:0]                 lpre;
        logic                       lc_prev;
        logic                       ev_prev;
    } ctp_state_s;

    ctp_state_s st_r;
    ctp_state_s st_nxt;
    logic       lc_rise;
    logic       ev_fall;
    logic       src_tick;
    logic       tick;

    // true for every mapped register offset
    function automatic logic ctp_addr_ok(input logic [ctp_pkg::ADDR_W-1:0] a);
        ctp_addr_ok = (a == ctp_pkg::OFS_LCTRL)   || (a == ctp_pkg::OFS_UCTRL)
                   || (a == ctp_pkg::OFS_CMP_LO)  || (a == ctp_pkg::OFS_CMP_HI)
                   || (a == ctp_pkg::OFS_DUTY_LO) || (a == ctp_pkg::OFS_DUTY_HI)
                   || (a == ctp_pkg::OFS_COUNT)   || (a == ctp_pkg::OFS_STATUS)
                   || (a == ctp_pkg::OFS_CFG);
    endfunction

    // edge detect on the low clock and the event input
    assign lc_rise = low_clock & ~st_r.lc_prev;
    assign ev_fall = st_r.ev_prev & ~event_input_pin; // R7 R9

    // source clock selection; slow mode leaves only the low-clock sources and the event input
    always_comb begin
        logic slow;
        logic lc8;
        slow = st_r.cfg[ctp_pkg::CFG_SLOW_BIT];
        lc8  = lc_rise & (&st_r.lpre);
        unique case (ctp_pkg::ctp_src_e'(st_r.lctrl[ctp_pkg::LC_SRC_LSB +: 3])) // R22
            ctp_pkg::CTP_SRC_DIV11: src_tick = (slow | st_r.cfg[ctp_pkg::CFG_DV_BIT]) ?
                                               lc8 : (&st_r.pre);
            ctp_pkg::CTP_SRC_DIV7:  src_tick = ~slow & (&st_r.pre[6:0]);
            ctp_pkg::CTP_SRC_DIV5:  src_tick = ~slow & (&st_r.pre[4:0]);
            ctp_pkg::CTP_SRC_DIV3:  src_tick = ~slow & (&st_r.pre[2:0]);
            ctp_pkg::CTP_SRC_LOW:   src_tick = lc_rise;
            ctp_pkg::CTP_SRC_DIV1:  src_tick = ~slow & st_r.pre[0];
            ctp_pkg::CTP_SRC_HIGH:  src_tick = ~slow;
            ctp_pkg::CTP_SRC_EXT:   src_tick = ev_fall; // R11
        endcase
    end

    // count enable per mode; timer mode has only the four prescaled sources
    assign tick = st_r.run & ((st_r.mode == ctp_pkg::CTP_MODE_EVENT) ? ev_fall : // R7
                  (st_r.mode == ctp_pkg::CTP_MODE_PWM) ? src_tick :
                  (st_r.mode == ctp_pkg::CTP_MODE_TIMER) ? (src_tick &
                  ~st_r.lctrl[ctp_pkg::LC_SRC_LSB + 2]) : 1'b0);

    // next state: bus channels, register writes, counter and output flop
    always_comb begin
        logic [15:0] inc;
        logic        new_run;
        logic        stopping;
        inc = st_r.cnt + 16'h0001;
        new_run = 1'b0;
        stopping = 1'b0;
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.pre = st_r.pre + 11'h001;
        st_nxt.lc_prev = low_clock;
        st_nxt.ev_prev = event_input_pin;
        if (lc_rise) begin
            st_nxt.lpre = st_r.lpre + 3'h1;
        end
        // write address and data are taken in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.awready = 1'b0;
            st_nxt.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.wready = 1'b0;
            st_nxt.wbyte  = s_axi_wdata[7:0];
            st_nxt.wlane  = s_axi_wstrb[0];
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = ctp_addr_ok(st_r.waddr) ? ctp_pkg::RESP_OKAY
                                                    : ctp_pkg::RESP_SLVERR;
            if (st_r.wlane) begin
                unique case (st_r.waddr)
                    ctp_pkg::OFS_LCTRL:   st_nxt.lctrl = st_r.wbyte;
                    ctp_pkg::OFS_CFG:     st_nxt.cfg = st_r.wbyte;
                    ctp_pkg::OFS_CMP_LO:  st_nxt.cmp[7:0] = st_r.wbyte;  // R6
                    ctp_pkg::OFS_CMP_HI:  st_nxt.cmp[15:8] = st_r.wbyte; // R6
                    ctp_pkg::OFS_DUTY_LO: st_nxt.duty_buf[7:0] = st_r.wbyte;  // R16
                    ctp_pkg::OFS_DUTY_HI: st_nxt.duty_buf[15:8] = st_r.wbyte; // R16
                    ctp_pkg::OFS_UCTRL: begin
                        new_run = st_r.wbyte[ctp_pkg::UC_RUN_BIT];
                        st_nxt.run = new_run; // R3
                        stopping = st_r.run & ~new_run; // R20
                        st_nxt.ff_init = st_r.wbyte[ctp_pkg::UC_FF_BIT];
                        st_nxt.mode = ctp_pkg::ctp_mode_e'(st_r.wbyte[1:0]);
                        // flop loads only while already stopped: a stopping write holds it
                        if (!st_r.run && !new_run) begin
                            st_nxt.ff = st_r.wbyte[ctp_pkg::UC_FF_BIT]; // R14 R20
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid  = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready  = 1'b1;
        end
        // read channel: one word per address handshake
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid  = 1'b1;
            st_nxt.rresp   = ctp_addr_ok(s_axi_araddr) ? ctp_pkg::RESP_OKAY
                                                       : ctp_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                ctp_pkg::OFS_LCTRL:   st_nxt.rdata = {24'h000000, st_r.lctrl};
                ctp_pkg::OFS_UCTRL:   st_nxt.rdata = {24'h000000, st_r.ff_init, 3'h0,
                                                      st_r.run, 1'b0, st_r.mode};
                ctp_pkg::OFS_CMP_LO:  st_nxt.rdata = {24'h000000, st_r.cmp[7:0]};
                ctp_pkg::OFS_CMP_HI:  st_nxt.rdata = {24'h000000, st_r.cmp[15:8]};
                ctp_pkg::OFS_DUTY_LO: st_nxt.rdata = {24'h000000, st_r.duty_act[7:0]}; // R17
                ctp_pkg::OFS_DUTY_HI: st_nxt.rdata = {24'h000000, st_r.duty_act[15:8]}; // R17
                ctp_pkg::OFS_COUNT:   st_nxt.rdata = {16'h0000, st_r.cnt};
                ctp_pkg::OFS_STATUS:  st_nxt.rdata = {30'h0, st_r.run, st_r.ff};
                ctp_pkg::OFS_CFG:     st_nxt.rdata = {24'h000000, st_r.cfg};
                default:              st_nxt.rdata = 32'h00000000;
            endcase
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid  = 1'b0;
            st_nxt.arready = 1'b1;
        end
        // cascaded counter, cleared while stopped; a stopping write skips its step so the pin keeps its level
        if (!st_r.run) begin
            st_nxt.cnt = 16'h0000;
        end else if (tick && !stopping) begin // R20
            if (st_r.mode == ctp_pkg::CTP_MODE_PWM) begin
                st_nxt.cnt = inc; // R12 R23
                if (inc == st_r.duty_act) begin
                    st_nxt.ff = ~st_nxt.ff; // R12
                end
                if (st_r.cnt == ctp_pkg::CNT_TOP) begin
                    st_nxt.ff = ~st_nxt.ff; // R13
                    st_nxt.irq = 1'b1;
                    st_nxt.duty_act = st_r.duty_buf; // R16
                end
            end else if (st_r.cnt == st_r.cmp) begin
                st_nxt.cnt = 16'h0000; // R2 R8
                st_nxt.irq = 1'b1;
            end else begin
                st_nxt.cnt = inc; // R1
            end
        end
        // a stopped or non-pwm timer passes duty writes straight through
        if (!(st_nxt.run && st_nxt.mode == ctp_pkg::CTP_MODE_PWM)) begin
            st_nxt.duty_act = st_nxt.duty_buf; // R16
        end
        st_nxt.pin = ~st_nxt.ff; // R15
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r         <= '0;
            st_r.awready <= 1'b1;
            st_r.wready  <= 1'b1;
            st_r.arready <= 1'b1;
            st_r.pin     <= 1'b1;
            st_r.lctrl   <= ctp_pkg::LCTRL_RST;
            st_r.cfg     <= ctp_pkg::CFG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready     = st_r.awready;
    assign s_axi_wready      = st_r.wready;
    assign s_axi_bvalid      = st_r.bvalid;
    assign s_axi_bresp       = st_r.bresp;
    assign s_axi_arready     = st_r.arready;
    assign s_axi_rvalid      = st_r.rvalid;
    assign s_axi_rresp       = st_r.rresp;
    assign s_axi_rdata       = st_r.rdata;
    assign pwm_output_pin    = st_r.pin;
    assign upper_counter_irq = st_r.irq;

    // checks on the counter, flop and bus
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic pwm_on;
    logic uc_wr;
    assign pwm_on = st_r.run && st_r.mode == ctp_pkg::CTP_MODE_PWM;
    assign uc_wr  = st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.wlane
                    && st_r.waddr == ctp_pkg::OFS_UCTRL;

    a_count_step: assert property ( // R1
        tick && st_r.mode == ctp_pkg::CTP_MODE_TIMER && st_r.cnt != st_r.cmp && !uc_wr
        |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
        else $error("timer count did not step by one");
    a_match_clear: assert property ( // R2
        tick && st_r.mode == ctp_pkg::CTP_MODE_TIMER && st_r.cnt == st_r.cmp && !uc_wr
        |=> st_r.cnt == 16'h0000 && upper_counter_irq)
        else $error("timer match did not clear and interrupt");
    a_event_hold: assert property ( // R7
        st_r.run && st_r.mode == ctp_pkg::CTP_MODE_EVENT && !ev_fall && !uc_wr
        |=> $stable(st_r.cnt) && !upper_counter_irq)
        else $error("event counter moved without a falling edge");
    a_event_match: assert property ( // R8
        tick && st_r.mode == ctp_pkg::CTP_MODE_EVENT && st_r.cnt == st_r.cmp && !uc_wr
        |=> st_r.cnt == 16'h0000 ##0 upper_counter_irq ##1 !upper_counter_irq)
        else $error("event match did not clear and interrupt once");
    a_pwm_match: assert property ( // R12
        pwm_on && tick && st_r.cnt + 16'h0001 == st_r.duty_act
        && st_r.cnt != ctp_pkg::CNT_TOP && !uc_wr
        |=> st_r.ff != $past(st_r.ff) && !upper_counter_irq && st_r.cnt != 16'h0000)
        else $error("pwm duty match did not toggle the flop");
    a_pwm_wrap: assert property ( // R13
        pwm_on && tick && st_r.cnt == ctp_pkg::CNT_TOP && st_r.duty_act != 16'h0000
        && !uc_wr |=> st_r.cnt == 16'h0000 && upper_counter_irq && st_r.ff != $past(st_r.ff))
        else $error("pwm overflow did not toggle, clear and interrupt");
    a_duty_load: assert property ( // R16
        pwm_on && tick && st_r.cnt == ctp_pkg::CNT_TOP && !uc_wr
        |=> st_r.duty_act == $past(st_r.duty_buf))
        else $error("duty buffer not loaded at period end");
    a_duty_hold: assert property ( // R17
        pwm_on && !(tick && st_r.cnt == ctp_pkg::CNT_TOP) && !uc_wr
        |=> $stable(st_r.duty_act))
        else $error("active duty changed mid period");
    a_pin_inverse: assert property ( // R15
        pwm_output_pin == !st_r.ff)
        else $error("pwm pin is not the inverse of the flop");
    a_stop_hold: assert property ( // R20
        uc_wr && st_r.run && !st_r.wbyte[ctp_pkg::UC_RUN_BIT]
        |=> !st_r.run && pwm_output_pin == $past(pwm_output_pin))
        else $error("stopping write changed the pin");
    a_init_load: assert property ( // R14
        uc_wr && !st_r.run && !st_r.wbyte[ctp_pkg::UC_RUN_BIT]
        |=> st_r.ff == $past(st_r.wbyte[ctp_pkg::UC_FF_BIT]))
        else $error("flop did not take its initial value");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");

    c_timer_irq: cover property (
        st_r.mode == ctp_pkg::CTP_MODE_TIMER && upper_counter_irq);
    c_event_irq: cover property (
        st_r.mode == ctp_pkg::CTP_MODE_EVENT && upper_counter_irq);
    c_pwm_period: cover property (pwm_on && upper_counter_irq ##[1:300] pwm_output_pin);
endmodule
`default_nettype wire

// *** testbench/ctp_far_side.sv ***
// far-side model: event input driver and low clock source
`timescale 1ns/1ps
`default_nettype none
module ctp_far_side (
    input  wire logic mclk,
    input  wire logic ev_go,
    output logic      ev_busy,
    output logic      event_input_pin,
    output logic      low_clock
);
    logic [2:0] lc_div = 3'h0;

    // free-running low clock, one period per 8 mclk
    always @(posedge mclk) begin
        lc_div <= lc_div + 3'h1;
    end
    assign low_clock = lc_div[2];

    // one event pulse per request; each level stands two machine cycles, 8 mclk
    initial begin
        event_input_pin = 1'b1;
        ev_busy = 1'b0;
        forever begin
            @(posedge mclk);
            if (ev_go) begin
                ev_busy <= 1'b1;
                repeat (8) @(posedge mclk);
                event_input_pin <= 1'b0;
                repeat (8) @(posedge mclk);
                event_input_pin <= 1'b1;
                repeat (8) @(posedge mclk);
                ev_busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the cascaded timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                        mclk;
    logic                        rst_n;
    logic [ctp_pkg::ADDR_W-1:0]  awaddr;
    logic                        awvalid;
    logic                        awready;
    logic [31:0]                 wdata;
    logic                        wvalid;
    logic                        wready;
    logic [1:0]                  bresp;
    logic                        bvalid;
    logic                        bready;
    logic [ctp_pkg::ADDR_W-1:0]  araddr;
    logic                        arvalid;
    logic                        arready;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic                        rvalid;
    logic                        rready;
    logic                        low_clk;
    logic                        ev_pin;
    logic                        ev_go;
    logic                        ev_busy;
    logic                        pwm_pin;
    logic                        irq;
    int                          n_errors = 0;
    int                          total_checks = 0;
    int                          irq_cnt = 0;

    ctp_timer dut_u (.mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_clock(low_clk),
        .event_input_pin(ev_pin), .pwm_output_pin(pwm_pin), .upper_counter_irq(irq));

    ctp_far_side far_u (.mclk(mclk), .ev_go(ev_go), .ev_busy(ev_busy),
        .event_input_pin(ev_pin), .low_clock(low_clk));

    // 25 mhz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // count irq pulses
    always @(posedge mclk) begin
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic hung(input string m);
        n_errors++;
        $display("mismatch at %0t: timeout in %s", $time, m);
        close_out();
    endtask

    // axi4-lite write: address and data together, wait for the response
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er = ctp_pkg::RESP_OKAY);
        int n;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) hung("write");
        chk(bresp, er, "bresp");
        @(posedge mclk);
    endtask

    // axi4-lite read
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n == 50) hung("read");
        @(posedge mclk);
    endtask

    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, {16'h0, e}, "read data");
        chk(r, ctp_pkg::RESP_OKAY, "rresp");
    endtask

    task automatic wait_irq(input int lim, output int n);
        for (n = 1; n <= lim; n++) begin
            @(posedge mclk);
            if (irq === 1'b1) break;
        end
        if (n > lim) hung("irq");
    endtask

    task automatic wait_pin(input logic v, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge mclk);
            if (pwm_pin === v) break;
        end
        if (n == lim) hung("pin");
    endtask

    task automatic pulse(input int k);
        int n;
        repeat (k) begin
            ev_go <= 1'b1;
            @(posedge mclk);
            ev_go <= 1'b0;
            for (n = 0; n < 40; n++) begin
                @(posedge mclk);
                if (!ev_busy) break;
            end
            if (n == 40) hung("event");
        end
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        chk(pwm_pin, 1'b1, "pin after reset");
        chk(irq, 1'b0, "irq after reset");
        rc(ctp_pkg::OFS_UCTRL, 16'h0000);
        rd(8'h40, d, r);
        chk(r, ctp_pkg::RESP_SLVERR, "unmapped read");
        wr(8'h40, 8'h5a, ctp_pkg::RESP_SLVERR);
        $display("test reset done");
    endtask

    task automatic t_timer();
        int n;
        int c;
        wr(ctp_pkg::OFS_LCTRL, 8'h30);
        wr(ctp_pkg::OFS_UCTRL, 8'h00);
        wr(ctp_pkg::OFS_CMP_HI, 8'h00);
        wr(ctp_pkg::OFS_CMP_LO, 8'h03);
        wr(ctp_pkg::OFS_UCTRL, 8'h08);
        wait_irq(200, n);
        wait_irq(200, n);
        chk(n, 32, "timer period");
        wr(ctp_pkg::OFS_UCTRL, 8'h00);
        c = irq_cnt;
        repeat (100) @(posedge mclk);
        chk(irq_cnt, c, "irq while stopped");
        rc(ctp_pkg::OFS_COUNT, 16'h0000);
        $display("test timer done");
    endtask

    task automatic t_event();
        int c;
        wr(ctp_pkg::OFS_UCTRL, 8'h01);
        wr(ctp_pkg::OFS_CMP_LO, 8'h02);
        wr(ctp_pkg::OFS_CMP_HI, 8'h00);
        wr(ctp_pkg::OFS_UCTRL, 8'h09);
        c = irq_cnt;
        pulse(2);
        chk(irq_cnt, c, "early irq");
        rc(ctp_pkg::OFS_COUNT, 16'h0002);
        pulse(1);
        chk(irq_cnt, c + 1, "match irq");
        rc(ctp_pkg::OFS_COUNT, 16'h0000);
        pulse(1);
        rc(ctp_pkg::OFS_COUNT, 16'h0001);
        wr(ctp_pkg::OFS_UCTRL, 8'h01);
        $display("test event done");
    endtask

    task automatic t_pwm();
        int    n;
        time   t0;
        logic  p;
        wr(ctp_pkg::OFS_LCTRL, 8'h60);
        wr(ctp_pkg::OFS_UCTRL, 8'h02);
        wr(ctp_pkg::OFS_DUTY_LO, 8'h02);
        wr(ctp_pkg::OFS_DUTY_HI, 8'h00);
        rc(ctp_pkg::OFS_DUTY_LO, 16'h0002);
        chk(pwm_pin, 1'b1, "idle pin");
        wr(ctp_pkg::OFS_UCTRL, 8'h0a);
        wait_pin(1'b0, 20);
        t0 = $time;
        wr(ctp_pkg::OFS_DUTY_LO, 8'h05);
        wr(ctp_pkg::OFS_DUTY_HI, 8'h00);
        rc(ctp_pkg::OFS_DUTY_LO, 16'h0002);
        wait_irq(70000, n);
        n = int'(($time - t0) / 40);
        chk(n >= 65533 && n <= 65535, 1'b1, "pwm period");
        chk(pwm_pin, 1'b1, "pin at wrap");
        rc(ctp_pkg::OFS_DUTY_LO, 16'h0005);
        wr(ctp_pkg::OFS_UCTRL, 8'h02);
        p = pwm_pin;
        repeat (20) @(posedge mclk);
        chk(pwm_pin, p, "held pin");
        chk(p, 1'b0, "pin after duty match");
        wr(ctp_pkg::OFS_UCTRL, 8'h02);
        chk(pwm_pin, 1'b1, "pin from cleared init bit");
        wr(ctp_pkg::OFS_UCTRL, 8'h82);
        chk(pwm_pin, 1'b0, "pin from init bit");
        rc(ctp_pkg::OFS_STATUS, 16'h0001);
        $display("test pwm done");
    endtask

    initial begin
        rst_n = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        ev_go = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_timer();
        t_event();
        t_pwm();
        close_out();
    end
endmodule
`default_nettype wire
